// ===== core/mls_ctrl.v
// Purpose: Low-speed management logic of a four-lane pluggable module.
// Assumes: sys_clk at 100 MHz; serial clock far slower than sys_clk.
// Notes: Serial slave has no clock stretching; pins sampled by 2 flops.
`include "mls_defs.vh"
`default_nettype none

module mls_ctrl #(
    parameter LANES = 4,
    parameter CNT_W = 28,
    parameter [CNT_W-1:0] INIT_CYCLES =
        `MLS_INIT_TIME_MS * `MLS_KHZ_PER_MHZ * `MLS_CLK_MHZ,
    parameter [CNT_W-1:0] RST_MIN_CYCLES = `MLS_RST_MIN_US * `MLS_CLK_MHZ,
    parameter [6:0] DEV_ADDR = `MLS_DEV_ADDR
) (
    input wire sys_clk,             // System clock
    input wire nrst,                // Synchronous reset, active low
    input wire module_select_n,     // Select pin, low enables serial
    input wire module_reset_n,      // Reset pin, active low
    input wire low_power_select,    // Low-power pin
    input wire scl_in,              // Serial clock pin level
    output wire scl_out,            // Serial clock drive value
    output wire scl_oe,             // Serial clock drive enable
    input wire sda_in,              // Serial data pin level
    output wire sda_out,            // Serial data drive value
    output wire sda_oe,             // Serial data drive enable
    output wire module_present_n,   // Presence pin, low when fitted
    output wire interrupt_n_out,    // Interrupt drive value
    output wire interrupt_n_oe,     // Interrupt sink enable
    input wire fault_event,         // Fault pulse from module logic
    output reg [LANES-1:0] lane_disable_reg, // Per-lane shutdown
    output reg high_power_ok_reg,   // High power class permitted
    output reg data_not_ready_reg,  // Status not yet valid
    output reg module_reset_reg     // Internal reset in progress
);

    localparam S_IDLE = 7'h01;
    localparam S_ADDR = 7'h02;
    localparam S_AACK = 7'h04;
    localparam S_WRX = 7'h08;
    localparam S_WACK = 7'h10;
    localparam S_RDX = 7'h20;
    localparam S_RACK = 7'h40;

    reg scl_s1, scl_s2, scl_s3;
    reg sda_s1, sda_s2, sda_s3;
    reg sel_s1, sel_s2;
    reg rst_s1, rst_s2;
    reg lp_s1, lp_s2;
    reg [CNT_W-1:0] low_cnt_reg;
    reg [CNT_W-1:0] init_cnt_reg;
    reg init_busy_reg;
    reg done_flag_reg;
    reg fault_flag_reg;
    reg [6:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] ptr_reg;
    reg ptr_valid_reg;
    reg rw_reg;
    reg sda_drv_reg;
    reg wr_en_reg;
    reg [7:0] wr_data_reg;
    reg [7:0] wr_addr_reg;
    reg flag_read_reg;
    wire [7:0] mem_rdata;
    reg [7:0] rd_byte;
    wire core_rst;
    wire scl_rise, scl_fall, bus_start, bus_stop;
    wire init_done;

    // ==========================================================
    // Pin synchronisers
    // Every pin passes two flops; third stage only for edges
    always @(posedge sys_clk) begin
        if (!nrst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            sel_s1 <= 1'b1;
            sel_s2 <= 1'b1;
            rst_s1 <= 1'b1;
            rst_s2 <= 1'b1;
            lp_s1 <= 1'b1;
            lp_s2 <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            sel_s1 <= module_select_n;
            sel_s2 <= sel_s1;
            rst_s1 <= module_reset_n;
            rst_s2 <= rst_s1;
            lp_s1 <= low_power_select;
            lp_s2 <= lp_s1;
        end
    end

    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    assign bus_stop = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

    // ==========================================================
    // Reset pulse filter and initialisation timer
    // Glitches shorter than the minimum never reach the core
    always @(posedge sys_clk) begin
        if (!nrst) begin
            low_cnt_reg <= {CNT_W{1'b0}};
            module_reset_reg <= 1'b0;
            init_busy_reg <= 1'b1;  // power-up runs the same init
            init_cnt_reg <= {CNT_W{1'b0}};
        end else if (!rst_s2) begin
            if (low_cnt_reg >= RST_MIN_CYCLES - 1'b1) begin
                module_reset_reg <= 1'b1;
            end else begin
                low_cnt_reg <= low_cnt_reg + 1'b1;
            end
        end else begin
            low_cnt_reg <= {CNT_W{1'b0}};
            if (module_reset_reg) begin
                module_reset_reg <= 1'b0;
                init_busy_reg <= 1'b1;
                init_cnt_reg <= {CNT_W{1'b0}};
            end else if (init_busy_reg) begin
                if (init_done) begin
                    init_busy_reg <= 1'b0;
                end else begin
                    init_cnt_reg <= init_cnt_reg + 1'b1;
                end
            end
        end
    end

    assign init_done = init_busy_reg && (init_cnt_reg >= INIT_CYCLES - 1'b1);
    assign core_rst = !nrst || module_reset_reg;

    // ==========================================================
    // Status, flags and settings
    // Set wins over read-clear; an event set as the read byte loads is cleared unread
    always @(posedge sys_clk) begin
        if (core_rst) begin
            data_not_ready_reg <= 1'b1;
            done_flag_reg <= 1'b0;
            fault_flag_reg <= 1'b0;
            lane_disable_reg <= `MLS_LANE_RESET;
            high_power_ok_reg <= 1'b0;
        end else begin
            if (init_done) begin
                data_not_ready_reg <= 1'b0;
            end
            done_flag_reg <= init_done | (done_flag_reg & ~flag_read_reg);
            fault_flag_reg <= fault_event | (fault_flag_reg & ~flag_read_reg);
            high_power_ok_reg <= ~lp_s2;
            if (wr_en_reg && wr_addr_reg == `MLS_LANE_ADDR) begin
                lane_disable_reg <= wr_data_reg[LANES-1:0];
            end
        end
    end

    // ==========================================================
    // Live bytes override memory contents
    always @* begin
        case (ptr_reg)
            `MLS_STATUS_ADDR: rd_byte = {7'h00, data_not_ready_reg};
            `MLS_FLAG_ADDR: rd_byte = {6'h00, fault_flag_reg, done_flag_reg};
            `MLS_LANE_ADDR: rd_byte = {{(8-LANES){1'b0}}, lane_disable_reg};
            default: rd_byte = mem_rdata;
        endcase
    end

    // ==========================================================
    // Two-wire slave
    // Deselect aborts any transfer and releases the data line
    always @(posedge sys_clk) begin
        if (core_rst) begin
            state_reg <= S_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            ptr_valid_reg <= 1'b0;
            rw_reg <= 1'b0;
            sda_drv_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            flag_read_reg <= 1'b0;
        end else begin
            wr_en_reg <= 1'b0;
            flag_read_reg <= 1'b0;
            if (sel_s2 || bus_stop) begin
                state_reg <= S_IDLE;
                sda_drv_reg <= 1'b0;
            end else if (bus_start) begin
                state_reg <= S_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_drv_reg <= 1'b0;
            end else begin
                case (state_reg)
                    S_ADDR: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s2};
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        end else if (scl_fall && bit_cnt_reg == `MLS_BYTE_BITS) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                sda_drv_reg <= 1'b1;
                                rw_reg <= shift_reg[0];
                                state_reg <= S_AACK;
                            end else begin
                                state_reg <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (rw_reg == `MLS_RW_READ) begin
                                shift_reg <= rd_byte;
                                sda_drv_reg <= ~rd_byte[7];
                                flag_read_reg <= (ptr_reg == `MLS_FLAG_ADDR);
                                state_reg <= S_RDX;
                            end else begin
                                sda_drv_reg <= 1'b0;
                                ptr_valid_reg <= 1'b0;
                                state_reg <= S_WRX;
                            end
                        end
                    end
                    S_WRX: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s2};
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        end else if (scl_fall && bit_cnt_reg == `MLS_BYTE_BITS) begin
                            sda_drv_reg <= 1'b1;
                            state_reg <= S_WACK;
                            if (!ptr_valid_reg) begin
                                ptr_reg <= shift_reg;
                                ptr_valid_reg <= 1'b1;
                            end else begin
                                wr_en_reg <= 1'b1;
                                wr_addr_reg <= ptr_reg;
                                wr_data_reg <= shift_reg;
                                ptr_reg <= ptr_reg + 1'b1;
                            end
                        end
                    end
                    S_WACK: begin
                        if (scl_fall) begin
                            sda_drv_reg <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            state_reg <= S_WRX;
                        end
                    end
                    S_RDX: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == `MLS_BYTE_BITS) begin
                                sda_drv_reg <= 1'b0;
                                state_reg <= S_RACK;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                sda_drv_reg <= ~shift_reg[6];
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            if (sda_s2) begin
                                state_reg <= S_IDLE;  // master ended the read
                            end else begin
                                ptr_reg <= ptr_reg + 1'b1;
                            end
                        end else if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            shift_reg <= rd_byte;
                            sda_drv_reg <= ~rd_byte[7];
                            flag_read_reg <= (ptr_reg == `MLS_FLAG_ADDR);
                            state_reg <= S_RDX;
                        end
                    end
                    S_IDLE: begin
                        sda_drv_reg <= 1'b0;
                    end
                    default: begin
                        state_reg <= S_IDLE;
                        sda_drv_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Management memory for bytes without live logic
    mls_mem #(
        .AW(8),
        .DW(8)
    ) u_mem (
        .sys_clk(sys_clk),
        .wr_en(wr_en_reg),
        .wr_addr(wr_addr_reg),
        .wr_data(wr_data_reg),
        .rd_addr(ptr_reg),
        .rd_data(mem_rdata)
    );

    // ==========================================================
    // Pin drivers: only sink or release, pull-ups give the high
    assign sda_out = 1'b0;
    assign sda_oe = sda_drv_reg;
    assign scl_out = 1'b0;  // no clock stretching
    assign scl_oe = 1'b0;
    assign module_present_n = 1'b0;
    assign interrupt_n_out = 1'b0;
    assign interrupt_n_oe = done_flag_reg | fault_flag_reg;

endmodule
`default_nettype wire

// ===== shared/mls_defs.vh
// Purpose: Shared constants of the module low-speed control block.
// Assumes: Included by bare name from the controller, host and bench files.
// Notes: Memory map positions and timing figures live here only.
`ifndef MLS_DEFS_VH
`define MLS_DEFS_VH

// ==========================================================
// Clock and timing
`define MLS_CLK_MHZ 100
`define MLS_KHZ_PER_MHZ 1000
`define MLS_INIT_TIME_MS 2000
`define MLS_RST_MIN_US 10

// ==========================================================
// Serial bus framing
`define MLS_DEV_ADDR 7'h50
`define MLS_BYTE_BITS 4'h8
`define MLS_RW_READ 1'b1

// ==========================================================
// Management memory map
`define MLS_STATUS_ADDR 8'h02
`define MLS_FLAG_ADDR 8'h03
`define MLS_LANE_ADDR 8'h56
`define MLS_LANE_RESET 4'h0
`define MLS_FLAG_DONE_BIT 0
`define MLS_FLAG_FAULT_BIT 1

`endif

// ===== core/mls_mem.v
// Purpose: Byte-wide management memory with registered read data.
// Assumes: Single clock, one write port, one read port.
// Notes: Contents are not cleared by reset; only live bytes are.
`default_nettype none

module mls_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input wire sys_clk,           // System clock
    input wire wr_en,             // Write strobe
    input wire [AW-1:0] wr_addr,  // Write address
    input wire [DW-1:0] wr_data,  // Write data
    input wire [AW-1:0] rd_addr,  // Read address
    output reg [DW-1:0] rd_data   // Read data, one cycle late
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // ==========================================================
    // Storage
    // Write and registered read
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule
`default_nettype wire

// ===== test/mls_ctrl_props.sv
// Purpose: Concurrent checks on the low-speed control pins.
// Assumes: Bound to mls_ctrl, sees its ports only.
// Notes: Windows allow for the two-flop pin synchronisers.
`default_nettype none

module mls_ctrl_props #(
    parameter LANES = 4,
    parameter RST_MIN_CYCLES = 8
) (
    input wire logic sys_clk, // clock
    input wire logic nrst, // reset
    input wire logic module_select_n, // select
    input wire logic module_reset_n, // reset pin
    input wire logic low_power_select, // low power
    input wire logic scl_in, // scl level
    input wire logic scl_out, // scl value
    input wire logic scl_oe, // scl enable
    input wire logic sda_in, // sda level
    input wire logic sda_out, // sda value
    input wire logic sda_oe, // sda enable
    input wire logic module_present_n, // present
    input wire logic interrupt_n_out, // int value
    input wire logic interrupt_n_oe, // int enable
    input wire logic fault_event, // fault
    input wire logic [LANES-1:0] lane_disable_reg, // lanes off
    input wire logic high_power_ok_reg, // power class
    input wire logic data_not_ready_reg, // not ready
    input wire logic module_reset_reg // core reset
);
    timeunit 1ns;
    timeprecision 100ps;
    // ========
    // Helpers
    // Saturating counts: cycles since reset, raw reset-pin low run
    logic [4:0] run_cnt;
    logic [7:0] low_cnt;
    always_ff @(posedge sys_clk) begin
        if (!nrst) run_cnt <= 5'h00;
        else if (run_cnt != 5'h1f) run_cnt <= run_cnt + 5'h01;
        if (module_reset_n) low_cnt <= 8'h00;
        else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ========
    // Properties
    a_present_low: assert property (module_present_n == 1'b0)
        else $error("present pin not low");
    a_int_sink_only: assert property (interrupt_n_out == 1'b0)
        else $error("interrupt drives high");
    a_scl_free: assert property (!scl_oe)
        else $error("serial clock driven");
    a_power_follow: assert property (run_cnt > 5'h04 |->
        high_power_ok_reg == !$past(low_power_select, 3)) else $error("power class lag");
    a_desel_quiet: assert property (module_select_n [*5] |-> !sda_oe)
        else $error("data driven while deselected");
    a_rst_quiet: assert property (module_reset_reg [*3] |->
        !sda_oe && data_not_ready_reg) else $error("active during reset");
    a_lane_default: assert property (module_reset_reg [*3] |->
        lane_disable_reg == '0) else $error("lanes not defaulted");
    a_short_ignored: assert property ($rose(module_reset_reg) |->
        low_cnt >= RST_MIN_CYCLES) else $error("short pulse taken");
    a_long_taken: assert property (run_cnt == 5'h1f &&
        low_cnt > RST_MIN_CYCLES + 4 |-> module_reset_reg) else $error("long pulse missed");
    a_int_on_done: assert property ($fell(data_not_ready_reg) |->
        ##[0:2] interrupt_n_oe) else $error("no completion interrupt");
    a_fault_int: assert property (fault_event && !data_not_ready_reg &&
        run_cnt == 5'h1f |-> ##[1:3] interrupt_n_oe) else $error("fault not flagged");
    c_core_reset: cover property ($rose(module_reset_reg));
    c_done: cover property ($fell(data_not_ready_reg));
    c_ack: cover property ($rose(sda_oe));
endmodule

bind mls_ctrl mls_ctrl_props #(.LANES(LANES), .RST_MIN_CYCLES(RST_MIN_CYCLES)) u_props (
    .sys_clk(sys_clk), .nrst(nrst), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .low_power_select(low_power_select),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .module_present_n(module_present_n),
    .interrupt_n_out(interrupt_n_out), .interrupt_n_oe(interrupt_n_oe),
    .fault_event(fault_event), .lane_disable_reg(lane_disable_reg),
    .high_power_ok_reg(high_power_ok_reg), .data_not_ready_reg(data_not_ready_reg),
    .module_reset_reg(module_reset_reg));
`default_nettype wire

// ===== test/mls_host.sv
// Purpose: Host controller model on the two-wire management bus.
// Assumes: Open-drain wires with pull-ups resolved by the bench.
// Notes: Serial clock stands high between frames; reads are one byte.
`include "mls_defs.vh"
`default_nettype none

module mls_host #(
    parameter [6:0] DEV = `MLS_DEV_ADDR
) (
    output logic scl_low, // sink clock
    output logic sda_low, // sink data
    input wire logic sda // data level
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam time Q = 20; // Quarter of an 80 ns period
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // ========
    // Framing; data moves with the clock high only for start and stop
    // Data waits a quarter after each clock fall: the slave's synchronisers
    // release its ACK up to 30 ns late, and an early change would be misread
    task automatic start();
        #Q sda_low = 1'b0;
        #Q scl_low = 1'b0;
        #Q sda_low = 1'b1;
        #Q scl_low = 1'b1;
    endtask
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl_low = 1'b0;
        #Q sda_low = 1'b0;
        #Q;
    endtask
    // One byte MSB first; ninth bit released, so reads end with NACK
    task automatic xb(input logic [7:0] b, input logic rd, output logic [7:0] r,
                      output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #Q sda_low = !rd && !b[i];
            #Q scl_low = 1'b0;
            #Q r = {r[6:0], sda};
            #Q scl_low = 1'b1;
        end
        #Q sda_low = 1'b0;
        #Q scl_low = 1'b0;
        #Q ack = !sda;
        #Q scl_low = 1'b1;
    endtask
    // ========
    // Memory map access
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k1, k2, k3;
        start();
        xb({DEV, 1'b0}, 1'b0, r, k1);
        xb(a, 1'b0, r, k2);
        xb(d, 1'b0, r, k3);
        stop();
        ok = k1 && k2 && k3;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k1, k2, k3, k4;
        start();
        xb({DEV, 1'b0}, 1'b0, r, k1);
        xb(a, 1'b0, r, k2);
        start();
        xb({DEV, 1'b1}, 1'b0, r, k3);
        xb(8'hff, 1'b1, d, k4);
        stop();
        ok = k1 && k2 && k3;
    endtask
endmodule
`default_nettype wire

// ===== test/mls_ctrl_tb_top.sv
// Purpose: Self-checking bench of the low-speed control block.
// Assumes: Short init and reset-filter counts set at the instance.
// Notes: Host drives the pins from the partner model.
`include "mls_defs.vh"
`default_nettype none

module mls_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic module_select_n = 1'b0;
    logic module_reset_n = 1'b1;
    logic low_power_select = 1'b1;
    logic fault_event = 1'b0;
    logic scl_out, scl_oe, sda_out, sda_oe, module_present_n, scl_low, sda_low;
    logic interrupt_n_out, interrupt_n_oe, high_power_ok_reg, data_not_ready_reg;
    logic module_reset_reg;
    logic [3:0] lane_disable_reg;
    wire logic scl, sda, int_n;
    int fail_count = 0;
    int compares = 0;
    // Open-drain wires; board pull-ups give the high level
    assign scl = !(scl_low || (scl_oe && !scl_out));
    assign sda = !(sda_low || (sda_oe && !sda_out));
    assign int_n = !(interrupt_n_oe && !interrupt_n_out);
    always #5 sys_clk = !sys_clk;
    mls_ctrl #(.INIT_CYCLES(28'h32), .RST_MIN_CYCLES(28'h8)) uut (
        .sys_clk(sys_clk), .nrst(nrst), .module_select_n(module_select_n),
        .module_reset_n(module_reset_n), .low_power_select(low_power_select),
        .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .module_present_n(module_present_n),
        .interrupt_n_out(interrupt_n_out), .interrupt_n_oe(interrupt_n_oe),
        .fault_event(fault_event), .lane_disable_reg(lane_disable_reg),
        .high_power_ok_reg(high_power_ok_reg), .data_not_ready_reg(data_not_ready_reg),
        .module_reset_reg(module_reset_reg));
    mls_host host (.scl_low(scl_low), .sda_low(sda_low), .sda(sda));
    // ========
    // Bench tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait, so a missing interrupt fails instead of hanging
    task automatic wait_int();
        int n;
        n = 0;
        while (int_n !== 1'b0 && n < 300) begin
            cyc(1);
            n++;
        end
        chk({7'h0, int_n}, 8'h00);
    endtask
    task automatic test_done();
        if (fail_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ========
    // Sequence
    initial begin
        logic [7:0] d;
        logic ok;
        cyc(3);
        nrst = 1'b1;
        wait_int();
        chk({7'h0, module_present_n}, 8'h00);
        host.rd_reg(`MLS_STATUS_ADDR, d, ok);
        chk(d, 8'h00);
        host.rd_reg(`MLS_FLAG_ADDR, d, ok);
        chk(d, 8'h01);
        cyc(5);
        chk({7'h0, int_n}, 8'h01);
        host.wr_reg(`MLS_LANE_ADDR, 8'h05, ok);
        cyc(5);
        chk({4'h0, lane_disable_reg}, 8'h05);
        host.rd_reg(`MLS_LANE_ADDR, d, ok);
        chk(d, 8'h05);
        module_select_n = 1'b1;
        cyc(5);
        host.wr_reg(`MLS_LANE_ADDR, 8'h0a, ok);
        chk({7'h0, ok}, 8'h00);
        chk({4'h0, lane_disable_reg}, 8'h05);
        module_select_n = 1'b0;
        for (int i = 0; i < 2; i++) begin
            low_power_select = i[0];
            cyc(5);
            chk({7'h0, high_power_ok_reg}, {7'h0, !i[0]});
        end
        fault_event = 1'b1;
        cyc(1);
        fault_event = 1'b0;
        cyc(4);
        chk({7'h0, int_n}, 8'h00);
        host.rd_reg(`MLS_FLAG_ADDR, d, ok);
        chk(d, 8'h02);
        module_reset_n = 1'b0;
        cyc(6);
        module_reset_n = 1'b1;
        cyc(6);
        chk({7'h0, module_reset_reg}, 8'h00);
        module_reset_n = 1'b0;
        cyc(20);
        chk({7'h0, module_reset_reg}, 8'h01);
        chk({7'h0, data_not_ready_reg}, 8'h01);
        chk({4'h0, lane_disable_reg}, 8'h00);
        module_reset_n = 1'b1;
        wait_int();
        host.rd_reg(`MLS_FLAG_ADDR, d, ok);
        chk(d, 8'h01);
        test_done();
    end
    // Hang guard, well beyond the sequence length
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
